// [verilog/air_regs.svh]
// Constants of the accumulator and index register set
`ifndef AIR_REGS_SVH
`define AIR_REGS_SVH
`define AIR_BYTE_W        8
`define AIR_WORD_W        16
`define AIR_ADDR_W        16
`define AIR_NUM_REGS      7
`define AIR_FLAGS_RST     8'hd0
`define AIR_SP_RST        16'h00ff
`define AIR_FLG_C         0
`define AIR_FLG_V         1
`define AIR_FLG_Z         2
`define AIR_FLG_N         3
`define AIR_FLG_I         4
`define AIR_FLG_H         5
`define AIR_FLG_X         6
`define AIR_FLG_S         7
`define AIR_Y_EXTRA_BYTES 1
`define AIR_Y_EXTRA_CYC   1
`endif

// [verilog/air_pkg.sv]
// Types of the accumulator and index register set
`include "air_regs.svh"
package air_pkg;
  typedef enum logic [4:0] {
    AIR_OP_NONE,
    AIR_OP_LD_A,
    AIR_OP_LD_B,
    AIR_OP_LD_D,
    AIR_OP_LD_X,
    AIR_OP_LD_Y,
    AIR_OP_LD_SP,
    AIR_OP_INC_X,
    AIR_OP_DEC_X,
    AIR_OP_INC_Y,
    AIR_OP_DEC_Y,
    AIR_OP_ADD_B_X,
    AIR_OP_ADD_B_Y,
    AIR_OP_A_TO_FLAGS,
    AIR_OP_FLAGS_TO_A,
    AIR_OP_DEC_ADJ,
    AIR_OP_ADD_AB,
    AIR_OP_SUB_AB,
    AIR_OP_CMP_AB,
    AIR_OP_PUSH,
    AIR_OP_PULL,
    AIR_OP_LD_FLAGS
  } air_op_type;

  typedef enum logic [1:0] {
    AIR_IDX_NONE,
    AIR_IDX_FIRST,
    AIR_IDX_SECOND
  } air_idx_type;

  typedef struct packed {
    air_op_type            op;
    logic [15:0]           data;
    air_idx_type           idx;
    logic [7:0]            offset;
  } air_cmd_type;

  typedef struct packed {
    logic [7:0]            accum_first;
    logic [7:0]            accum_second;
    logic [15:0]           accum_double;
    logic [15:0]           index_reg_first;
    logic [15:0]           index_reg_second;
    logic [15:0]           stack_pointer_reg;
    logic [7:0]            condition_flags_reg;
  } air_state_type;
endpackage

// [verilog/air_dec_adj.sv]
// Decimal adjust of one byte after packed-decimal addition
`timescale 1ns/1ps
module air_dec_adj (
  input  wire logic [7:0] i_value,
  input  wire logic       i_carry,
  input  wire logic       i_half,
  output logic      [7:0] o_value,
  output logic            o_carry
);
  logic [7:0] corr;
  logic       hi_fix;

  always_comb begin
    hi_fix = i_carry || (i_value[7:4] > 4'h9) ||
             ((i_value[7:4] >= 4'h9) && (i_value[3:0] > 4'h9));
    corr   = 8'h00;
    if (i_half || (i_value[3:0] > 4'h9)) begin
      corr[3:0] = 4'h6;
    end
    if (hi_fix) begin
      corr[7:4] = 4'h6;
    end
    o_value = i_value + corr;
    o_carry = hi_fix;
  end
endmodule

// [verilog/air_reg_set.sv]
// Accumulator, index, stack and flag registers with their operand datapath
// How it works
// - Effective addresses are plain 16-bit values in one 64-Kbyte map; no I/O port exists.
// - Address formation is combinational, so external and internal operands cost the same.
// - Seven registers are held here and none is reachable through the memory address.
// - Two 8-bit accumulators can each be loaded and used as operands.
// - The double accumulator reads and writes both accumulators as one 16-bit operand.
// - Add-to-index adds only the second accumulator, unsigned, to either index register.
// - Flag transfers exist only between the flags and the first accumulator.
// - Decimal adjust corrects only the first accumulator.
// - Add, subtract and compare between accumulators always take first op second.
// - The first index register plus the 8-bit offset forms the effective address.
// - The first index register also loads, increments and decrements as a counter.
// - Indexed addressing through the second index register reports one extra code byte and one extra cycle.
// - The stack pointer decrements after a push and increments before a pull.
`timescale 1ns/1ps
`include "air_regs.svh"
module air_reg_set
  import air_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  input  wire air_cmd_type   i_cmd,
  output air_state_type      o_state,
  output logic        [15:0] o_eff_addr,
  output logic        [15:0] o_stack_addr,
  output logic        [1:0]  o_extra_bytes,
  output logic        [1:0]  o_extra_cycles
);
  logic [7:0]  a_ff;
  logic [7:0]  b_ff;
  logic [15:0] x_ff;
  logic [15:0] y_ff;
  logic [15:0] sp_ff;
  logic [7:0]  flags_ff;
  logic [15:0] ea_ff;
  logic [15:0] sa_ff;
  logic [1:0]  xb_ff;
  logic [1:0]  xc_ff;
  logic [7:0]  nxt_a;
  logic [7:0]  nxt_flags;
  logic [8:0]  sum9;
  logic [8:0]  dif9;
  logic [4:0]  half5;
  logic [7:0]  daa_val;
  logic        daa_c;
  logic [15:0] nxt_ea;

  // ----------------------------------------------------------------
  // Arithmetic between accumulators
  // ----------------------------------------------------------------
  assign sum9  = {1'b0, a_ff} + {1'b0, b_ff};
  assign dif9  = {1'b0, a_ff} - {1'b0, b_ff};
  assign half5 = {1'b0, a_ff[3:0]} + {1'b0, b_ff[3:0]};

  air_dec_adj u_dec_adj (
    .i_value (a_ff),
    .i_carry (flags_ff[`AIR_FLG_C]),
    .i_half  (flags_ff[`AIR_FLG_H]),
    .o_value (daa_val),
    .o_carry (daa_c)
  );

  always_comb begin
    nxt_a     = a_ff;
    nxt_flags = flags_ff;
    case (i_cmd.op)
      AIR_OP_LD_A:       nxt_a = i_cmd.data[7:0];
      AIR_OP_LD_D:       nxt_a = i_cmd.data[15:8];
      AIR_OP_FLAGS_TO_A: nxt_a = flags_ff;
      AIR_OP_A_TO_FLAGS: begin
        // The X mask may be cleared but never set by this transfer; AIR_OP_LD_FLAGS can set it
        nxt_flags = a_ff;
        nxt_flags[`AIR_FLG_X] = a_ff[`AIR_FLG_X] & flags_ff[`AIR_FLG_X];
      end
      AIR_OP_LD_FLAGS:   nxt_flags = i_cmd.data[7:0];
      AIR_OP_DEC_ADJ: begin
        nxt_a = daa_val;
        nxt_flags[`AIR_FLG_C] = daa_c;
        nxt_flags[`AIR_FLG_N] = daa_val[7];
        nxt_flags[`AIR_FLG_Z] = (daa_val == 8'h00);
      end
      AIR_OP_ADD_AB: begin
        nxt_a = sum9[7:0];
        nxt_flags[`AIR_FLG_C] = sum9[8];
        nxt_flags[`AIR_FLG_H] = half5[4];
        nxt_flags[`AIR_FLG_N] = sum9[7];
        nxt_flags[`AIR_FLG_Z] = (sum9[7:0] == 8'h00);
        nxt_flags[`AIR_FLG_V] = (a_ff[7] == b_ff[7]) && (sum9[7] != a_ff[7]);
      end
      AIR_OP_SUB_AB, AIR_OP_CMP_AB: begin
        if (i_cmd.op == AIR_OP_SUB_AB) begin
          nxt_a = dif9[7:0];
        end
        nxt_flags[`AIR_FLG_C] = dif9[8];
        nxt_flags[`AIR_FLG_N] = dif9[7];
        nxt_flags[`AIR_FLG_Z] = (dif9[7:0] == 8'h00);
        nxt_flags[`AIR_FLG_V] = (a_ff[7] != b_ff[7]) && (dif9[7] != a_ff[7]);
      end
      default: nxt_a = a_ff;
    endcase
  end

  // ----------------------------------------------------------------
  // Accumulators and flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      a_ff     <= 8'h00;
      flags_ff <= `AIR_FLAGS_RST;
    end else begin
      a_ff     <= nxt_a;
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      b_ff <= 8'h00;
    end else if (i_cmd.op == AIR_OP_LD_B) begin
      b_ff <= i_cmd.data[7:0];
    end else if (i_cmd.op == AIR_OP_LD_D) begin
      b_ff <= i_cmd.data[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Index registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      x_ff <= 16'h0000;
    end else begin
      case (i_cmd.op)
        AIR_OP_LD_X:    x_ff <= i_cmd.data;
        AIR_OP_INC_X:   x_ff <= x_ff + 16'h0001;
        AIR_OP_DEC_X:   x_ff <= x_ff - 16'h0001;
        AIR_OP_ADD_B_X: x_ff <= x_ff + {8'h00, b_ff};
        default:        x_ff <= x_ff;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      y_ff <= 16'h0000;
    end else begin
      case (i_cmd.op)
        AIR_OP_LD_Y:    y_ff <= i_cmd.data;
        AIR_OP_INC_Y:   y_ff <= y_ff + 16'h0001;
        AIR_OP_DEC_Y:   y_ff <= y_ff - 16'h0001;
        AIR_OP_ADD_B_Y: y_ff <= y_ff + {8'h00, b_ff};
        default:        y_ff <= y_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Stack pointer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sp_ff <= `AIR_SP_RST;
      sa_ff <= 16'h0000;
    end else begin
      case (i_cmd.op)
        AIR_OP_LD_SP: sp_ff <= i_cmd.data;
        AIR_OP_PUSH: begin
          sa_ff <= sp_ff;
          sp_ff <= sp_ff - 16'h0001;
        end
        AIR_OP_PULL: begin
          sa_ff <= sp_ff + 16'h0001;
          sp_ff <= sp_ff + 16'h0001;
        end
        default: sp_ff <= sp_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Effective address and cost of the second index register
  // ----------------------------------------------------------------
  always_comb begin
    case (i_cmd.idx)
      AIR_IDX_FIRST:  nxt_ea = x_ff + {8'h00, i_cmd.offset};
      AIR_IDX_SECOND: nxt_ea = y_ff + {8'h00, i_cmd.offset};
      default:        nxt_ea = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ea_ff <= 16'h0000;
      xb_ff <= 2'h0;
      xc_ff <= 2'h0;
    end else begin
      ea_ff <= nxt_ea;
      xb_ff <= (i_cmd.idx == AIR_IDX_SECOND) ? 2'(`AIR_Y_EXTRA_BYTES) : 2'h0;
      xc_ff <= (i_cmd.idx == AIR_IDX_SECOND) ? 2'(`AIR_Y_EXTRA_CYC) : 2'h0;
    end
  end

  // Registers leave only through this state port, never via an address
  assign o_state.accum_first         = a_ff;
  assign o_state.accum_second        = b_ff;
  assign o_state.accum_double        = {a_ff, b_ff};
  assign o_state.index_reg_first     = x_ff;
  assign o_state.index_reg_second    = y_ff;
  assign o_state.stack_pointer_reg   = sp_ff;
  assign o_state.condition_flags_reg = flags_ff;
  assign o_eff_addr                  = ea_ff;
  assign o_stack_addr                = sa_ff;
  assign o_extra_bytes               = xb_ff;
  assign o_extra_cycles              = xc_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_add_to_first: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.op == AIR_OP_ADD_AB |=> a_ff == $past(a_ff) + $past(b_ff))
    else $error("add did not land in first accumulator");
  a_cmp_keeps_acc: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.op == AIR_OP_CMP_AB |=> $stable(a_ff) && $stable(b_ff))
    else $error("compare changed an accumulator");
  a_sub_direction: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.op == AIR_OP_SUB_AB |=> a_ff == $past(a_ff) - $past(b_ff))
    else $error("subtract direction wrong");
  a_double_pair: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.op == AIR_OP_LD_D |=> o_state.accum_double == $past(i_cmd.data))
    else $error("double load mismatch");
  a_abx_adds_b: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.op == AIR_OP_ADD_B_X |=> x_ff == $past(x_ff) + {8'h00, $past(b_ff)})
    else $error("index add wrong");
  a_flags_to_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.op == AIR_OP_FLAGS_TO_A |=> a_ff == $past(flags_ff))
    else $error("flag copy wrong");
  a_b_untouched: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.op == AIR_OP_DEC_ADJ |=> $stable(b_ff))
    else $error("decimal adjust touched second accumulator");
  a_eff_address: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.idx == AIR_IDX_FIRST |=> o_eff_addr == $past(x_ff) + {8'h00, $past(i_cmd.offset)})
    else $error("effective address wrong");
  a_push_order: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.op == AIR_OP_PUSH |=> o_stack_addr == $past(sp_ff) && sp_ff == $past(sp_ff) - 16'h0001)
    else $error("push order wrong");
  a_y_penalty: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_cmd.idx == AIR_IDX_SECOND |=> o_extra_cycles == 2'h1 && o_extra_bytes == 2'h1)
    else $error("second index cost missing");

  c_add: cover property (@(posedge i_clk)
    i_cmd.op == AIR_OP_ADD_AB ##1 i_cmd.op == AIR_OP_DEC_ADJ);
  c_push_pull: cover property (@(posedge i_clk)
    i_cmd.op == AIR_OP_PUSH ##1 i_cmd.op == AIR_OP_PULL);
  c_idx_y: cover property (@(posedge i_clk) i_cmd.idx == AIR_IDX_SECOND);
endmodule

// [tb/air_seq_model.sv]
// Sequencer model that hands one decoded command to the register set
`timescale 1ns/1ps
module air_seq_model
  import air_pkg::*;
(
  input  wire logic  i_clk,
  output air_cmd_type o_cmd
);
  initial o_cmd = '0;

  // Launch at a falling edge, withdraw after one cycle so nothing repeats
  task automatic issue(input air_cmd_type c);
    @(negedge i_clk);
    o_cmd = c;
    @(negedge i_clk);
    o_cmd = '0;
  endtask
endmodule

// [tb/cpu_accumulator_index_register_set_bench.sv]
// Self-checking bench of the accumulator and index register set
`timescale 1ns/1ps
module cpu_accumulator_index_register_set_bench;
  import air_pkg::*;
  typedef struct packed {
    air_cmd_type cmd;
    logic [3:0]  sel;
    logic [15:0] exp;
  } air_row_type;

  logic          i_clk    = 1'b0;
  logic          i_arst_n = 1'b0;
  air_cmd_type   cmd;
  air_state_type st;
  logic [15:0]   eff;
  logic [15:0]   stk;
  logic [1:0]    xb;
  logic [1:0]    xc;
  int            n_fail     = 0;
  int            num_checks = 0;
  air_row_type   rows[$];

  always #50 i_clk = ~i_clk;

  air_seq_model i_seq (
    .i_clk(i_clk),
    .o_cmd(cmd)
  );

  air_reg_set i_dut (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_cmd(cmd),
    .o_state(st),
    .o_eff_addr(eff),
    .o_stack_addr(stk),
    .o_extra_bytes(xb),
    .o_extra_cycles(xc)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] seen(input logic [3:0] s);
    case (s)
      4'h0: seen = {8'h00, st.accum_first};
      4'h1: seen = {8'h00, st.accum_second};
      4'h2: seen = st.accum_double;
      4'h3: seen = st.index_reg_first;
      4'h4: seen = st.index_reg_second;
      4'h5: seen = st.stack_pointer_reg;
      4'h6: seen = {8'h00, st.condition_flags_reg};
      4'h7: seen = eff;
      4'h8: seen = stk;
      4'h9: seen = {14'h0000, xb};
      default: seen = {14'h0000, xc};
    endcase
  endfunction

  function automatic void add(input air_op_type op, input logic [15:0] d,
                              input air_idx_type ix, input logic [7:0] off,
                              input logic [3:0] s, input logic [15:0] e);
    rows.push_back('{'{op, d, ix, off}, s, e});
  endfunction

  task automatic check(input string name, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    @(negedge i_clk);
    i_arst_n = 1'b1;
    add(AIR_OP_LD_D, 16'h12f0, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0012);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h1, 16'h00f0);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h2, 16'h12f0);
    add(AIR_OP_LD_X, 16'h1000, AIR_IDX_NONE, 8'h00, 4'h3, 16'h1000);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_FIRST, 8'hff, 4'h7, 16'h10ff);
    add(AIR_OP_ADD_B_X, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h3, 16'h10f0);
    add(AIR_OP_INC_X, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h3, 16'h10f1);
    add(AIR_OP_DEC_X, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h3, 16'h10f0);
    add(AIR_OP_LD_Y, 16'h20ff, AIR_IDX_NONE, 8'h00, 4'h4, 16'h20ff);
    add(AIR_OP_ADD_B_Y, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h4, 16'h21ef);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_SECOND, 8'h10, 4'h9, 16'h0001);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_SECOND, 8'h10, 4'ha, 16'h0001);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h9, 16'h0000);
    add(AIR_OP_ADD_AB, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0002);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h1, 16'h00f0);
    add(AIR_OP_SUB_AB, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0012);
    add(AIR_OP_CMP_AB, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0012);
    add(AIR_OP_FLAGS_TO_A, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h00d1);
    add(AIR_OP_LD_A, 16'h0005, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0005);
    add(AIR_OP_A_TO_FLAGS, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h6, 16'h0005);
    add(AIR_OP_LD_A, 16'h0040, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0040);
    add(AIR_OP_A_TO_FLAGS, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h6, 16'h0000);
    add(AIR_OP_LD_B, 16'h0028, AIR_IDX_NONE, 8'h00, 4'h1, 16'h0028);
    add(AIR_OP_LD_A, 16'h0019, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0019);
    add(AIR_OP_ADD_AB, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0041);
    add(AIR_OP_DEC_ADJ, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0047);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h1, 16'h0028);
    add(AIR_OP_PUSH, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h8, 16'h00ff);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h5, 16'h00fe);
    add(AIR_OP_PULL, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h8, 16'h00ff);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h5, 16'h00ff);
    add(AIR_OP_LD_X, 16'hffff, AIR_IDX_NONE, 8'h00, 4'h3, 16'hffff);
    add(AIR_OP_NONE, 16'h0000, AIR_IDX_FIRST, 8'h02, 4'h7, 16'h0001);
    add(AIR_OP_LD_SP, 16'h0123, AIR_IDX_NONE, 8'h00, 4'h5, 16'h0123);
    add(AIR_OP_INC_Y, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h4, 16'h21f0);
    add(AIR_OP_DEC_Y, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h4, 16'h21ef);
    add(AIR_OP_LD_FLAGS, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h6, 16'h0000);
    add(AIR_OP_LD_B, 16'h0099, AIR_IDX_NONE, 8'h00, 4'h1, 16'h0099);
    add(AIR_OP_LD_A, 16'h0099, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0099);
    add(AIR_OP_ADD_AB, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0032);
    add(AIR_OP_DEC_ADJ, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h0098);
    add(AIR_OP_FLAGS_TO_A, 16'h0000, AIR_IDX_NONE, 8'h00, 4'h0, 16'h002b);
    foreach (rows[k]) begin
      i_seq.issue(rows[k].cmd);
      check($sformatf("row %0d", k), rows[k].exp, seen(rows[k].sel));
    end
    $display("table test done");
    // Reset in mid-run must restore the stack pointer, flags, both accumulators and the first index register
    @(negedge i_clk);
    i_arst_n = 1'b0;
    #10;
    check("stack", 16'h00ff, st.stack_pointer_reg);
    check("flags", 16'h00d0, {8'h00, st.condition_flags_reg});
    check("double", 16'h0000, st.accum_double);
    check("index", 16'h0000, st.index_reg_first);
    @(negedge i_clk);
    i_arst_n = 1'b1;
    i_seq.issue('{AIR_OP_LD_D, 16'h8001, AIR_IDX_NONE, 8'h00});
    check("double", 16'h8001, st.accum_double);
    check("upper", 16'h0080, {8'h00, st.accum_first});
    $display("reset test done");
    summarize();
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    $display("[ERR] run expected done seen hang");
    summarize();
  end
endmodule
